/* rtl/fcs_pkg.sv */
package fcs_pkg;
  // clock and timing
  localparam int CLK_MHZ    = 200;                 // core clock rate
  localparam int NS_PER_US  = 1000;                // ns to cycles divisor
  localparam int T_SETUP_NS = 10;                  // address setup before strobe
  localparam int T_WE_NS    = 100;                 // least write pulse width
  localparam int T_WC_NS    = 200;                 // least write cycle time
  localparam int T_ACC_NS   = 200;                 // most access time on read
  localparam int T_REC_NS   = 30;                  // recovery after read strobe
  localparam int SYNC_CYC   = 2;                   // input synchroniser depth
  localparam logic [7:0] SU_CYC  = 8'((T_SETUP_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US);
  localparam logic [7:0] WE_CYC  = 8'((T_WE_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US);
  localparam logic [7:0] WC_CYC  = 8'((T_WC_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US);
  localparam logic [7:0] ACC_CYC = 8'((T_ACC_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US);
  localparam logic [7:0] REC_CYC = 8'((T_REC_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US);
  localparam logic [7:0] WE_END  = SU_CYC + WE_CYC;                      // strobe release
  localparam logic [7:0] RD_CAP  = SU_CYC + ACC_CYC + 8'(SYNC_CYC);      // read capture
  localparam logic [7:0] RD_END  = RD_CAP + REC_CYC;                     // read cycle end

  // command codes, one byte per device
  localparam logic [7:0] CMD_WRITE_SETUP = 8'h40;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_CONFIRM     = 8'hd0;
  localparam logic [7:0] CMD_SUSPEND     = 8'hb0;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_READ_ARRAY  = 8'hff;
  localparam logic [7:0] CMD_CLEAR_STAT  = 8'h50;

  // device status bit positions, high device adds HI_OFS
  localparam int ST_READY = 7;
  localparam int ST_SUSP  = 6;
  localparam int ST_EFAIL = 5;
  localparam int ST_WFAIL = 4;
  localparam int ST_VPP   = 3;
  localparam int HI_OFS   = 8;

  // register map, byte addresses
  localparam int          ADR_W    = 8;
  localparam logic [7:0] REG_CTRL  = 8'h00;
  localparam logic [7:0] REG_ADDR  = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_STAT  = 8'h0c;
  localparam logic [7:0] REG_RDATA = 8'h10;

  // control fields
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_WIDE   = 4;
  localparam int CTRL_GO     = 8;

  // controller status fields
  localparam int STAT_BUSY    = 0;
  localparam int STAT_DONE    = 1;
  localparam int STAT_REFUSED = 2;
  localparam int STAT_LOCK    = 3;
  localparam int STAT_SEQERR  = 4;
  localparam int STAT_EFAIL   = 5;
  localparam int STAT_WFAIL   = 6;
  localparam int STAT_VPP     = 7;
  localparam int STAT_SUSP    = 8;
  localparam int STAT_CARDRDY = 9;
  localparam int STAT_WORD    = 16;

  localparam int CARD_AW = 24;                     // card address width

  // software operations
  typedef enum logic [2:0] {
    OP_READ    = 3'h0,
    OP_WRITE   = 3'h1,
    OP_ERASE   = 3'h2,
    OP_SUSPEND = 3'h3,
    OP_RESUME  = 3'h4,
    OP_CLEAR   = 3'h5,
    OP_RSTAT   = 3'h6,
    OP_RARRAY  = 3'h7
  } fcs_op_e;

  // card pin group driven by the controller
  typedef struct packed {
    logic [CARD_AW-1:0] addr;
    logic [15:0]        dout;
    logic               doe;
    logic               low_byte_select_n;
    logic               high_byte_select_n;
    logic               oe_n;
    logic               we_n;
  } fcs_pins_s;
endpackage

/* rtl/fcs_host.sv */
`timescale 1ns/1ps
// Functional notes
// - data write is setup code then data
// - clear voltage flag before write or erase
// - host masks reserved status bits 2..0
// - erase is setup then confirm in block
// - wide mode doubles every command code
// - wide mode needs both ready bits set
// - bits 4 and 5 both mean sequence error
// - toggle strobes between status reads
// - suspend polls ready and suspend, resume confirms
module fcs_host (
  // clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // wishbone slave
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [7:0]         wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o,
  // card pins
  output fcs_pkg::fcs_pins_s      pins_o,
  input  wire logic [15:0]        card_data_i,
  input  wire logic               card_ready_pin_i
);

  // one-hot engine states
  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_WR1  = 5'b00010,
    S_WR2  = 5'b00100,
    S_RD   = 5'b01000,
    S_CHK  = 5'b10000
  } fcs_state_e;

  fcs_state_e                 state_ff;     // engine state
  logic [7:0]                 cnt_ff;       // cycle count within a pin cycle
  fcs_pkg::fcs_pins_s         pins_ff;      // registered pin drive
  logic [15:0]                dat_s1_ff;    // data synchroniser stage 1
  logic [15:0]                dat_s2_ff;    // data synchroniser stage 2
  logic                       rdy_s1_ff;    // ready pin stage 1
  logic                       rdy_s2_ff;    // ready pin stage 2
  logic [15:0]                rd_ff;        // last word read from card
  fcs_pkg::fcs_op_e           op_ff;        // selected operation
  logic                       wide_ff;      // 16-bit paired mode
  logic                       go_ff;        // one-cycle start pulse
  logic [fcs_pkg::CARD_AW-1:0] addr_ff;     // target card address
  logic [15:0]                wdata_ff;     // data for a data write
  logic                       done_ff;      // last operation finished
  logic                       refused_ff;   // last start was refused
  logic                       lock_ff;      // low voltage seen, clear needed
  logic                       seqerr_ff;    // command sequence error
  logic                       efail_ff;     // erase failure
  logic                       wfail_ff;     // write failure
  logic                       vpp_ff;       // voltage low reported
  logic                       susp_ff;      // erase reported suspended
  logic                       ack_ff;       // bus acknowledge
  logic [31:0]                dat_ff;       // bus read data
  logic                       busy;         // engine not idle
  logic                       poll_ok;      // polled status is final
  logic [15:0]                code1;        // first command, doubled if wide
  logic [15:0]                code2;        // second bus write value
  logic [7:0]                 cmd1;         // first command byte
  logic                       bus_hit;      // bus cycle being answered

  assign busy    = (state_ff != S_IDLE);
  assign bus_hit = wb_cyc_i && wb_stb_i && !ack_ff;
  // first command byte per operation
  always_comb begin
    case (op_ff)
      fcs_pkg::OP_WRITE:   cmd1 = fcs_pkg::CMD_WRITE_SETUP;
      fcs_pkg::OP_ERASE:   cmd1 = fcs_pkg::CMD_ERASE_SETUP;
      fcs_pkg::OP_SUSPEND: cmd1 = fcs_pkg::CMD_SUSPEND;
      fcs_pkg::OP_RESUME:  cmd1 = fcs_pkg::CMD_CONFIRM;
      fcs_pkg::OP_CLEAR:   cmd1 = fcs_pkg::CMD_CLEAR_STAT;
      fcs_pkg::OP_RSTAT:   cmd1 = fcs_pkg::CMD_READ_STATUS;
      default:             cmd1 = fcs_pkg::CMD_READ_ARRAY;
    endcase
  end
  // doubled codes in wide mode, low byte only otherwise
  always_comb begin
    code1 = wide_ff ? {cmd1, cmd1} : {8'h00, cmd1};
    code2 = wide_ff ? {fcs_pkg::CMD_CONFIRM, fcs_pkg::CMD_CONFIRM} : {8'h00, fcs_pkg::CMD_CONFIRM};
    if (op_ff == fcs_pkg::OP_WRITE) code2 = wide_ff ? wdata_ff : {8'h00, wdata_ff[7:0]};
  end
  // polled status is final once every device is ready, and for a suspend also reports suspended
  always_comb begin
    poll_ok = rd_ff[fcs_pkg::ST_READY] &&
              (!wide_ff || rd_ff[fcs_pkg::ST_READY + fcs_pkg::HI_OFS]);
    if (op_ff == fcs_pkg::OP_SUSPEND) begin
      poll_ok = poll_ok && rd_ff[fcs_pkg::ST_SUSP] &&
                (!wide_ff || rd_ff[fcs_pkg::ST_SUSP + fcs_pkg::HI_OFS]);
    end
  end
  // two-flop synchronisers for card inputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_s1_ff <= 16'h0000;
      dat_s2_ff <= 16'h0000;
      rdy_s1_ff <= 1'b0;
      rdy_s2_ff <= 1'b0;
    end else begin
      dat_s1_ff <= card_data_i;
      dat_s2_ff <= dat_s1_ff;
      rdy_s1_ff <= card_ready_pin_i;
      rdy_s2_ff <= rdy_s1_ff;
    end
  end
  // wishbone slave: ack one cycle after request, dropped next cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff   <= 1'b0;
      dat_ff   <= 32'h0000_0000;
      go_ff    <= 1'b0;
      op_ff    <= fcs_pkg::OP_READ;
      wide_ff  <= 1'b0;
      addr_ff  <= '0;
      wdata_ff <= 16'h0000;
    end else begin
      ack_ff <= bus_hit;
      go_ff  <= 1'b0;
      dat_ff <= 32'h0000_0000;
      // writes take effect only while the engine is idle
      if (bus_hit && wb_we_i && !busy) begin
        case (wb_adr_i)
          fcs_pkg::REG_CTRL: begin
            if (wb_sel_i[0]) begin
              op_ff   <= fcs_pkg::fcs_op_e'(wb_dat_i[fcs_pkg::CTRL_OP_LSB +: 3]);
              wide_ff <= wb_dat_i[fcs_pkg::CTRL_WIDE];
            end
            if (wb_sel_i[1]) go_ff <= wb_dat_i[fcs_pkg::CTRL_GO];
          end
          fcs_pkg::REG_ADDR:  addr_ff <= wb_dat_i[fcs_pkg::CARD_AW-1:0];
          fcs_pkg::REG_WDATA: wdata_ff <= wb_dat_i[15:0];
          default: ;
        endcase
      end
      // reads answer every address, unmapped as zero
      if (bus_hit && !wb_we_i) begin
        case (wb_adr_i)
          fcs_pkg::REG_CTRL:  dat_ff <= {23'h0, 1'b0, 3'h0, wide_ff, 1'b0, op_ff};
          fcs_pkg::REG_ADDR:  dat_ff <= {8'h00, addr_ff};
          fcs_pkg::REG_WDATA: dat_ff <= {16'h0000, wdata_ff};
          fcs_pkg::REG_STAT:  dat_ff <= {rd_ff & 16'hf8f8, 6'h00, rdy_s2_ff, susp_ff, vpp_ff,
                                         wfail_ff, efail_ff, seqerr_ff, lock_ff, refused_ff,
                                         done_ff, busy};
          fcs_pkg::REG_RDATA: dat_ff <= {16'h0000, rd_ff};
          default:            dat_ff <= 32'h0000_0000;
        endcase
      end
    end
  end
  // engine state and pin cycles
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= S_IDLE;
      cnt_ff   <= 8'h00;
      pins_ff  <= '{addr: '0, dout: 16'h0000, doe: 1'b0, low_byte_select_n: 1'b1,
                    high_byte_select_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
      rd_ff    <= 16'h0000;
    end else begin
      cnt_ff <= cnt_ff + 8'h01;
      case (state_ff)
        // wait for a start pulse
        S_IDLE: begin
          cnt_ff <= 8'h00;
          if (go_ff && !((op_ff == fcs_pkg::OP_WRITE || op_ff == fcs_pkg::OP_ERASE) && lock_ff)) begin
            state_ff <= (op_ff == fcs_pkg::OP_READ) ? S_RD : S_WR1;
          end
        end
        // bus write cycles, command then second value
        S_WR1, S_WR2: begin
          if (cnt_ff == 8'h00) begin
            pins_ff.addr <= addr_ff;
            pins_ff.dout <= (state_ff == S_WR1) ? code1 : code2;
            pins_ff.doe  <= 1'b1;
          end
          if (cnt_ff == fcs_pkg::SU_CYC) begin
            pins_ff.low_byte_select_n  <= 1'b0;
            pins_ff.high_byte_select_n <= !wide_ff;
            pins_ff.we_n               <= 1'b0;
          end
          if (cnt_ff == fcs_pkg::WE_END) begin
            pins_ff.we_n               <= 1'b1;
            pins_ff.low_byte_select_n  <= 1'b1;
            pins_ff.high_byte_select_n <= 1'b1;
          end
          if (cnt_ff == fcs_pkg::WC_CYC) begin
            pins_ff.doe <= 1'b0;
            cnt_ff      <= 8'h00;
            case (op_ff)
              fcs_pkg::OP_WRITE, fcs_pkg::OP_ERASE: state_ff <= (state_ff == S_WR1) ? S_WR2 : S_RD;
              fcs_pkg::OP_SUSPEND, fcs_pkg::OP_RSTAT: state_ff <= S_RD;
              default: state_ff <= S_IDLE;
            endcase
          end
        end
        // one read cycle, strobes released after each read
        S_RD: begin
          if (cnt_ff == 8'h00) begin
            pins_ff.addr <= addr_ff;
            pins_ff.doe  <= 1'b0;
          end
          if (cnt_ff == fcs_pkg::SU_CYC) begin
            pins_ff.low_byte_select_n  <= 1'b0;
            pins_ff.high_byte_select_n <= !wide_ff;
            pins_ff.oe_n               <= 1'b0;
          end
          if (cnt_ff == fcs_pkg::RD_CAP) begin
            rd_ff                      <= wide_ff ? dat_s2_ff : {8'h00, dat_s2_ff[7:0]};
            pins_ff.oe_n               <= 1'b1;
            pins_ff.low_byte_select_n  <= 1'b1;
            pins_ff.high_byte_select_n <= 1'b1;
          end
          if (cnt_ff == fcs_pkg::RD_END) begin
            cnt_ff   <= 8'h00;
            state_ff <= S_CHK;
          end
        end
        // finish or poll again
        S_CHK: begin
          cnt_ff <= 8'h00;
          state_ff <= (op_ff == fcs_pkg::OP_READ || op_ff == fcs_pkg::OP_RSTAT || poll_ok) ? S_IDLE : S_RD;
        end
        default: begin
          state_ff <= S_IDLE;
          cnt_ff   <= 8'h00;
        end
      endcase
    end
  end
  // result flags from the final status word
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_ff    <= 1'b0;
      refused_ff <= 1'b0;
      lock_ff    <= 1'b0;
      seqerr_ff  <= 1'b0;
      efail_ff   <= 1'b0;
      wfail_ff   <= 1'b0;
      vpp_ff     <= 1'b0;
      susp_ff    <= 1'b0;
    end else if (state_ff == S_IDLE && go_ff) begin
      done_ff    <= 1'b0;
      refused_ff <= 1'b0;
      if ((op_ff == fcs_pkg::OP_WRITE || op_ff == fcs_pkg::OP_ERASE) && lock_ff) begin
        refused_ff <= 1'b1;
        done_ff    <= 1'b1;
      end
    end else if (state_ff == S_CHK && (op_ff == fcs_pkg::OP_READ || op_ff == fcs_pkg::OP_RSTAT || poll_ok)) begin
      done_ff <= 1'b1;
      if (op_ff != fcs_pkg::OP_READ) begin
        efail_ff  <= rd_ff[fcs_pkg::ST_EFAIL] || (wide_ff && rd_ff[fcs_pkg::ST_EFAIL + fcs_pkg::HI_OFS]);
        wfail_ff  <= rd_ff[fcs_pkg::ST_WFAIL] || (wide_ff && rd_ff[fcs_pkg::ST_WFAIL + fcs_pkg::HI_OFS]);
        vpp_ff    <= rd_ff[fcs_pkg::ST_VPP] || (wide_ff && rd_ff[fcs_pkg::ST_VPP + fcs_pkg::HI_OFS]);
        susp_ff   <= rd_ff[fcs_pkg::ST_SUSP] && (!wide_ff || rd_ff[fcs_pkg::ST_SUSP + fcs_pkg::HI_OFS]);
        seqerr_ff <= rd_ff[fcs_pkg::ST_EFAIL] && rd_ff[fcs_pkg::ST_WFAIL] &&
                     (!wide_ff || (rd_ff[fcs_pkg::ST_EFAIL + fcs_pkg::HI_OFS] &&
                                   rd_ff[fcs_pkg::ST_WFAIL + fcs_pkg::HI_OFS]));
        if (rd_ff[fcs_pkg::ST_VPP] || (wide_ff && rd_ff[fcs_pkg::ST_VPP + fcs_pkg::HI_OFS])) begin
          lock_ff <= 1'b1;
        end
      end
    end else if (state_ff == S_WR1 && cnt_ff == fcs_pkg::WC_CYC && op_ff == fcs_pkg::OP_CLEAR) begin
      done_ff   <= 1'b1;
      lock_ff   <= 1'b0;
      efail_ff  <= 1'b0;
      wfail_ff  <= 1'b0;
      vpp_ff    <= 1'b0;
      seqerr_ff <= 1'b0;
    end else if (state_ff == S_WR1 && cnt_ff == fcs_pkg::WC_CYC &&
                 (op_ff == fcs_pkg::OP_RESUME || op_ff == fcs_pkg::OP_RARRAY)) begin
      done_ff <= 1'b1;
      if (op_ff == fcs_pkg::OP_RESUME) susp_ff <= 1'b0;
    end
  end
  // outputs straight from flops
  assign pins_o   = pins_ff;
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;
endmodule

/* bench/fcs_host_properties.sv */
`timescale 1ns/1ps
module fcs_host_checker (
  // clock and reset
  input wire logic               clk_i,
  input wire logic               rst_i,
  // bus side
  input wire logic               wb_cyc_i,
  input wire logic               wb_stb_i,
  input wire logic               wb_we_i,
  input wire logic [7:0]         wb_adr_i,
  input wire logic [3:0]         wb_sel_i,
  input wire logic [31:0]        wb_dat_i,
  input wire logic [31:0]        wb_dat_o,
  input wire logic               wb_ack_o,
  // card side
  input wire fcs_pkg::fcs_pins_s pins_o,
  input wire logic [15:0]        card_data_i,
  input wire logic               card_ready_pin_i
);
  logic [7:0] we_low_ff; // cycles with write strobe low

  // count the write strobe width
  always_ff @(posedge clk_i) begin
    if (rst_i || pins_o.we_n) begin
      we_low_ff <= 8'h00;
    end else begin
      we_low_ff <= we_low_ff + 8'h01;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_next_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered next cycle");
  a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero without ack");
  a_reset_idle: assert property ($past(rst_i) |-> pins_o.we_n && pins_o.oe_n && !wb_ack_o)
    else $error("pins not idle after reset");
  a_strobes_apart: assert property (!(!pins_o.oe_n && !pins_o.we_n))
    else $error("read and write strobes low together");
  a_we_width_min: assert property ($rose(pins_o.we_n) |-> we_low_ff >= fcs_pkg::WE_CYC)
    else $error("write strobe too short");
  a_write_data_held: assert property (!pins_o.we_n |=> $stable(pins_o.dout) && $stable(pins_o.addr) && pins_o.doe)
    else $error("data or address moved around write strobe");
  a_select_with_we: assert property ($fell(pins_o.we_n) |-> !pins_o.low_byte_select_n)
    else $error("write strobe without low select");
  a_read_bus_free: assert property (!pins_o.oe_n |-> !pins_o.doe)
    else $error("controller drives data during read");
  a_status_toggle: assert property ($rose(pins_o.oe_n) |-> pins_o.low_byte_select_n)
    else $error("select not released with read strobe");
  a_read_strobe_len: assert property ($fell(pins_o.oe_n) |-> !pins_o.oe_n [*8])
    else $error("read strobe too short");
endmodule

bind fcs_host fcs_host_checker u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pins_o(pins_o), .card_data_i(card_data_i),
  .card_ready_pin_i(card_ready_pin_i)
);

/* bench/fcs_card_model.sv */
`timescale 1ns/1ps
module fcs_card_model #(
  parameter int WR_CYC = 60,
  parameter int ER_CYC = 300
) (
  // clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // card pins and test controls
  input  wire fcs_pkg::fcs_pins_s pins_i,
  input  wire logic               vpp_low_i,
  input  wire logic               fail_i,
  output logic [15:0]             data_o,
  output logic                    ready_o
);
  logic [7:0] st_ff;       // device status
  logic [7:0] mem_ff [16]; // small array
  logic [7:0] snap_ff;     // value latched at read strobe fall
  logic [7:0] c;           // command byte on the bus
  logic       stat_ff;     // status output mode
  logic       wr_ff;       // write setup seen
  logic       er_ff;       // erase setup seen
  logic       ers_ff;      // engine runs an erase
  logic       we_q;        // last write strobe
  logic       oe_q;        // last read strobe
  logic       sel_q;       // last low select
  int         cnt_ff;      // engine time left
  assign c = pins_i.dout[7:0];
  // both devices answer alike; unselected bus shows the inverse
  assign data_o = (!pins_i.oe_n && !pins_i.low_byte_select_n) ? {snap_ff, snap_ff} : ~{snap_ff, snap_ff};
  assign ready_o = st_ff[7];

  // command port and engine
  always @(posedge clk_i) begin
    we_q <= pins_i.we_n;
    oe_q <= pins_i.oe_n;
    sel_q <= pins_i.low_byte_select_n;
    if (oe_q && !pins_i.oe_n) snap_ff <= stat_ff ? st_ff : mem_ff[pins_i.addr[3:0]];
    if (rst_i) begin
      st_ff <= 8'h80;
      stat_ff <= 1'b0;
      wr_ff <= 1'b0;
      er_ff <= 1'b0;
      ers_ff <= 1'b0;
      cnt_ff <= 0;
      for (int i = 0; i < 16; i++) mem_ff[i] <= 8'h3c ^ 8'(i);
    end else begin
      // engine runs unless suspended
      if (cnt_ff > 0 && !st_ff[6]) begin
        cnt_ff <= vpp_low_i ? 0 : cnt_ff - 1;
        if (vpp_low_i || cnt_ff == 1) st_ff[7] <= 1'b1;
        if (vpp_low_i) st_ff[3] <= 1'b1;
        if (vpp_low_i || (cnt_ff == 1 && fail_i)) st_ff[ers_ff ? 5 : 4] <= 1'b1;
      end
      // command latched at the write strobe rise
      if (!we_q && pins_i.we_n && !sel_q) begin
        if (wr_ff) begin
          mem_ff[pins_i.addr[3:0]] <= c;
          wr_ff <= 1'b0;
          st_ff[7] <= 1'b0;
          cnt_ff <= WR_CYC;
          ers_ff <= 1'b0;
        end else if (er_ff) begin
          er_ff <= 1'b0;
          stat_ff <= 1'b1;
          if (c == fcs_pkg::CMD_CONFIRM) begin
            st_ff[7] <= 1'b0;
            cnt_ff <= ER_CYC;
            ers_ff <= 1'b1;
          end else st_ff[5:4] <= 2'b11;
        end else if (!st_ff[7]) begin
          if (c == fcs_pkg::CMD_SUSPEND && ers_ff) st_ff[7:6] <= 2'b11;
        end else if (st_ff[6]) begin
          if (c == fcs_pkg::CMD_READ_ARRAY) stat_ff <= 1'b0;
          if (c == fcs_pkg::CMD_READ_STATUS) stat_ff <= 1'b1;
          if (c == fcs_pkg::CMD_CONFIRM) st_ff[7:6] <= 2'b00;
        end else begin
          case (c)
            fcs_pkg::CMD_WRITE_SETUP: begin
              wr_ff <= 1'b1;
              stat_ff <= 1'b1;
            end
            fcs_pkg::CMD_ERASE_SETUP: er_ff <= 1'b1;
            fcs_pkg::CMD_READ_STATUS: stat_ff <= 1'b1;
            fcs_pkg::CMD_CLEAR_STAT: st_ff[5:3] <= 3'b000;
            fcs_pkg::CMD_READ_ARRAY: stat_ff <= 1'b0;
            default: ;
          endcase
        end
      end
    end
  end
endmodule

/* bench/test_fcs_host.sv */
`timescale 1ns/1ps
module test_fcs_host;
  logic               clk_i;
  logic               rst_i;
  logic               wb_cyc_i;
  logic               wb_stb_i;
  logic               wb_we_i;
  logic [7:0]         wb_adr_i;
  logic [3:0]         wb_sel_i;
  logic [31:0]        wb_dat_i;
  logic [31:0]        wb_dat_o;
  logic               wb_ack_o;
  fcs_pkg::fcs_pins_s pins_o;
  logic [15:0]        card_data_i;
  logic               card_ready_pin_i;
  logic               vpp_low;  // programming voltage low
  logic               fail_op;  // engine fails next operation
  logic [31:0]        rd_val;   // last bus read
  logic [31:0]        addr;     // random target
  logic [31:0]        data;     // random data
  logic [63:0]        note;     // expected value and mask
  logic [63:0]        exp_q[$]; // notes waiting for reads
  int                 failures;
  int                 n_tests;
  int                 seed;
  int                 k;

  // 200 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  fcs_host u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pins_o(pins_o), .card_data_i(card_data_i),
    .card_ready_pin_i(card_ready_pin_i));
  fcs_card_model u_card (.clk_i(clk_i), .rst_i(rst_i), .pins_i(pins_o), .vpp_low_i(vpp_low),
    .fail_i(fail_op), .data_o(card_data_i), .ready_o(card_ready_pin_i));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // one classic bus cycle, waits for ack under a bound
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int i;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= 4'hf;
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (!wb_ack_o && i < 50);
    if (!wb_ack_o) begin
      failures++;
      complete_run();
    end
    rd_val = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // read with a note for the monitor, zero mask means no compare
  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp, input logic [31:0] mask);
    exp_q.push_back({exp, mask});
    wb(1'b0, adr, 32'h0);
  endtask

  // start an operation and poll until done
  task automatic run_op(input logic [2:0] op, input logic wide);
    int i;
    wb(1'b1, fcs_pkg::REG_CTRL, {23'h0, 1'b1, 3'h0, wide, 1'b0, op});
    i = 0;
    do begin
      rd_chk(fcs_pkg::REG_STAT, 32'h0, 32'h0);
      i++;
    end while (rd_val[1:0] !== 2'b10 && i < 400);
    if (rd_val[1:0] !== 2'b10) begin
      failures++;
      complete_run();
    end
  endtask

  // monitor takes the oldest note at each read ack
  always @(posedge clk_i) begin
    if (wb_ack_o && !wb_we_i && exp_q.size() > 0) begin
      note = exp_q.pop_front();
      if (note[31:0] != 32'h0) check("read data", wb_dat_o & note[31:0], note[63:32]);
    end
  end

  // main sequence
  initial begin
    seed = 32'h608a;
    failures = 0;
    n_tests = 0;
    rst_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    vpp_low = 1'b0;
    fail_op = 1'b0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd_chk(fcs_pkg::REG_STAT, 32'h0, 32'hff);
    wb(1'b1, fcs_pkg::REG_ADDR, 32'h5);
    run_op(fcs_pkg::OP_READ, 1'b0);
    rd_chk(fcs_pkg::REG_RDATA, 32'h39, 32'hff);
    $display("test reset and array read done");
    // good byte write, then failing wide write
    for (k = 0; k < 2; k++) begin
      addr = $random(seed);
      data = $random(seed);
      fail_op <= k[0];
      wb(1'b1, fcs_pkg::REG_ADDR, {28'h0, addr[3:0]});
      rd_chk(fcs_pkg::REG_ADDR, {28'h0, addr[3:0]}, 32'hff_ffff);
      wb(1'b1, fcs_pkg::REG_WDATA, {24'h0, data[7:0]});
      run_op(fcs_pkg::OP_WRITE, k[0]);
      rd_chk(fcs_pkg::REG_STAT, k[0] ? 32'h9090_0242 : 32'h0080_0202, 32'hffff_03ff);
    end
    run_op(fcs_pkg::OP_RARRAY, 1'b0);
    run_op(fcs_pkg::OP_READ, 1'b0);
    rd_chk(fcs_pkg::REG_RDATA, {24'h0, data[7:0]}, 32'hff);
    run_op(fcs_pkg::OP_RSTAT, 1'b0);
    rd_chk(fcs_pkg::REG_STAT, 32'h0090_0000, 32'hffff_0000);
    run_op(fcs_pkg::OP_READ, 1'b0);
    rd_chk(fcs_pkg::REG_RDATA, 32'h90, 32'hff);
    run_op(fcs_pkg::OP_CLEAR, 1'b0);
    $display("test data write done");
    // good then failing block erase
    for (k = 0; k < 2; k++) begin
      fail_op <= k[0];
      wb(1'b1, fcs_pkg::REG_ADDR, $random(seed));
      run_op(fcs_pkg::OP_ERASE, 1'b0);
      rd_chk(fcs_pkg::REG_STAT, k[0] ? 32'h00a0_0222 : 32'h0080_0202, 32'hffff_03ff);
    end
    run_op(fcs_pkg::OP_CLEAR, 1'b0);
    $display("test block erase done");
    // low voltage, refused start, clear, then retry
    fail_op <= 1'b0;
    vpp_low <= 1'b1;
    run_op(fcs_pkg::OP_WRITE, 1'b0);
    rd_chk(fcs_pkg::REG_STAT, 32'h0098_02ca, 32'hffff_03ff);
    run_op(fcs_pkg::OP_ERASE, 1'b0);
    rd_chk(fcs_pkg::REG_STAT, 32'he, 32'hf);
    vpp_low <= 1'b0;
    run_op(fcs_pkg::OP_CLEAR, 1'b0);
    rd_chk(fcs_pkg::REG_STAT, 32'h0, 32'h8);
    run_op(fcs_pkg::OP_WRITE, 1'b1);
    rd_chk(fcs_pkg::REG_STAT, 32'h8080_0202, 32'hffff_03ff);
    run_op(fcs_pkg::OP_RESUME, 1'b0);
    rd_chk(fcs_pkg::REG_STAT, 32'h202, 32'h3ff);
    $display("test low voltage done");
    complete_run();
  end
endmodule
